// [hdl/spi_cmd_bank_regs.vh]
// Register offsets, field positions, reset values and timing counts of the command bank
`ifndef SPI_CMD_BANK_REGS_VH
`define SPI_CMD_BANK_REGS_VH
// Byte offsets on the Avalon-MM slave (word aligned)
`define OFS_CMD_BASE 6'h00
`define OFS_CTRL 6'h20
`define OFS_BITRATE 6'h24
`define OFS_LEADDLY 6'h28
`define OFS_NEGDLY 6'h2c
`define OFS_NEXTDLY 6'h30
`define OFS_SEQCTL 6'h34
`define OFS_SEQSTAT 6'h38
`define OFS_POLARITY 6'h3c
// Command word fields
`define CW_LEAD_EN 15
`define CW_NEG_EN 14
`define CW_NEXT_EN 13
`define CW_LSB_FIRST 12
`define CW_LEN_HI 11
`define CW_LEN_LO 8
`define CW_KEEP 7
`define CW_SEL_HI 6
`define CW_SEL_LO 4
`define CW_DIV_HI 3
`define CW_DIV_LO 2
`define CW_CLOCK_POLARITY 1
`define CW_CLOCK_PHASE 0
`define CW_RESET 16'h070d
// Control register fields
`define CTL_ENABLE 0
`define CTL_MASTER 1
`define CTL_MULTI 2
`define CTL_START 3
`define CTL_FOURSEL 4
// Other reset values
`define BITRATE_RESET 8'hff
// Fixed part of the next-access delay, in peripheral clocks
`define NEXT_EXTRA_CLKS 4'h2
`endif

// [hdl/spi_command_format_bank.v]
// Command-word bank and master sequencer of a synchronous serial port, with Avalon-MM registers
// Contract
// [R1] Eight command words, referenced in programmed sequence
// [R2] Slave mode uses command word 0 only
// [R3] Clock lead delay: one period or register
// [R4] Select negate delay: one period or register
// [R5] Next-access delay: period plus two clocks
// [R6] Software clears delay bits for slave mode
// [R7] Bit 12 chooses MSB or LSB first
// [R8] Length codes: 8 bits, then 9..16
// [R9] Keep bit holds select until next access
// [R10] Select choice drives one of eight lines
// [R11] Asserted line takes its polarity bit
// [R12] Multi-master with choice 0: all negated
// [R13] Four-line channel: choices 4..7 negated
// [R14] Divider select divides rate by 1..8
// [R15] Polarity bit sets clock idle level
// [R16] Phase bit picks sampling edge parity
// [R17] Software leaves active word alone mid-transfer
// [R18] Software leaves word 0 in slave mode
// [R19] Both ends share polarity and phase
// [R20] Read-only 3-bit command pointer
// [R21] Rate is clock over 2(n+1)2^N
// [R22] Lead delay codes mean 1..8 periods
// [R23] Pointer advances and wraps after transfer
// [R24] Command words reset to 0x070d
//
// Our own choices: the Avalon-MM slave port and the address map.
`include "spi_cmd_bank_regs.vh"
module spi_command_format_bank #(
    parameter NUM_CMD = 8
) (
    // System
    input wire clk_sys,
    input wire rst,
    // Avalon-MM slave
    input wire [5:0] avsAddress,
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsWriteData,
    input wire [3:0] avsByteEnable,
    output reg [31:0] avsReadData,
    output reg avsWaitRequest,
    // Transmit and receive words
    input wire [15:0] txWord,
    output reg [15:0] rxWord,
    output reg rxValid,
    // Serial pins
    output reg sclkOut,
    output reg sclkOe,
    input wire sclkIn,
    output reg mosiOut,
    input wire misoIn,
    output reg slaveMisoOut,
    input wire mosiIn,
    output reg [7:0] selectOut,
    input wire selectIn0
);
    localparam ST_IDLE = 3'h0;
    localparam ST_LEAD = 3'h1;
    localparam ST_SHIFT = 3'h2;
    localparam ST_NEG = 3'h3;
    localparam ST_NEXT = 3'h4;
    localparam ST_EXTRA = 3'h5;

    reg [15:0] cmdWord_ff [0:NUM_CMD-1];
    reg [4:0] ctrl_ff;
    reg [7:0] bitRate_ff;
    reg [2:0] leadDly_ff;
    reg [2:0] negDly_ff;
    reg [2:0] nextDly_ff;
    reg [2:0] seqLen_ff;
    reg [2:0] cmdPtr_ff;
    reg [7:0] selPol_ff;
    reg [2:0] state_ff;
    reg [11:0] rateCnt_ff;
    reg [3:0] halfCnt_ff;
    reg [4:0] edgeCnt_ff;
    reg [15:0] shift_ff;
    reg [15:0] rxShift_ff;
    reg keepSel_ff;
    reg [7:0] heldSel_ff;
    reg busy_ff;
    reg startPend_ff;
    reg [2:0] sclkSync_ff;
    reg [2:0] selSync_ff;
    reg [2:0] mosiSync_ff;
    reg [4:0] slvCnt_ff;
    reg [15:0] slvShift_ff;
    reg [15:0] slvOut_ff;

    wire [15:0] cw = cmdWord_ff[cmdPtr_ff];
    wire [15:0] cw0 = cmdWord_ff[0];
    wire isMaster = ctrl_ff[`CTL_MASTER];
    wire isEnabled = ctrl_ff[`CTL_ENABLE];
    wire [4:0] bitLen = lenOf(cw[`CW_LEN_HI:`CW_LEN_LO]);
    wire [4:0] bitLen0 = lenOf(cw0[`CW_LEN_HI:`CW_LEN_LO]);
    // Half bit period in peripheral clocks: (n+1)*2^N; a full period is twice that
    wire [11:0] halfPeriod = {4'h0, bitRate_ff} + 12'h001 << cw[`CW_DIV_HI:`CW_DIV_LO]; // [R21] [R14]

    // Data length code: 0..7 give 8 bits, 8..15 give 9..16
    function [4:0] lenOf;
        input [3:0] code;
        begin
            if (code[3]) begin
                lenOf = {1'b0, code} + 5'h01; // [R8]
            end else begin
                lenOf = 5'h08; // [R8]
            end
        end
    endfunction

    // Select lines for a command, with suppressed choices giving all negated
    function [7:0] selOf;
        input [2:0] choice;
        input [7:0] pol;
        input multi;
        input fourSel;
        reg [7:0] oneHot;
        begin
            oneHot = 8'h01 << choice; // [R10]
            if ((multi && choice == 3'h0) || (fourSel && choice[2])) begin // [R12] [R13]
                oneHot = 8'h00;
            end
            selOf = (oneHot & pol) | (~oneHot & ~pol); // [R11]
        end
    endfunction

    // Bus slave: every access answers one cycle after it is raised
    integer i;
    always @(posedge clk_sys) begin
        if (rst) begin
            for (i = 0; i < NUM_CMD; i = i + 1) begin
                cmdWord_ff[i] <= `CW_RESET; // [R24]
            end
            ctrl_ff <= 5'h00;
            bitRate_ff <= `BITRATE_RESET;
            leadDly_ff <= 3'h0;
            negDly_ff <= 3'h0;
            nextDly_ff <= 3'h0;
            seqLen_ff <= 3'h0;
            selPol_ff <= 8'h00;
            avsWaitRequest <= 1'b1;
            avsReadData <= 32'h00000000;
            startPend_ff <= 1'b0;
        end else begin
            avsWaitRequest <= ~((avsRead | avsWrite) & avsWaitRequest);
            if (busy_ff) begin
                startPend_ff <= 1'b0;
            end
            if ((avsRead | avsWrite) && avsWaitRequest) begin
                avsReadData <= 32'h00000000;
                if (avsAddress[5] == 1'b0) begin
                    if (avsWrite) begin
                        if (avsByteEnable[0]) begin
                            cmdWord_ff[avsAddress[4:2]][7:0] <= avsWriteData[7:0];
                        end
                        if (avsByteEnable[1]) begin
                            cmdWord_ff[avsAddress[4:2]][15:8] <= avsWriteData[15:8];
                        end
                    end
                    avsReadData <= {16'h0000, cmdWord_ff[avsAddress[4:2]]};
                end else begin
                    case (avsAddress)
                        `OFS_CTRL: begin
                            if (avsWrite && avsByteEnable[0]) begin
                                ctrl_ff <= {avsWriteData[4], 1'b0, avsWriteData[2:0]};
                                if (avsWriteData[`CTL_START]) begin
                                    startPend_ff <= 1'b1;
                                end
                            end
                            avsReadData <= {27'h0, ctrl_ff[4], startPend_ff | busy_ff,
                                ctrl_ff[2:0]};
                        end
                        `OFS_BITRATE: begin
                            if (avsWrite && avsByteEnable[0]) bitRate_ff <= avsWriteData[7:0];
                            avsReadData <= {24'h0, bitRate_ff};
                        end
                        `OFS_LEADDLY: begin
                            if (avsWrite && avsByteEnable[0]) leadDly_ff <= avsWriteData[2:0];
                            avsReadData <= {29'h0, leadDly_ff};
                        end
                        `OFS_NEGDLY: begin
                            if (avsWrite && avsByteEnable[0]) negDly_ff <= avsWriteData[2:0];
                            avsReadData <= {29'h0, negDly_ff};
                        end
                        `OFS_NEXTDLY: begin
                            if (avsWrite && avsByteEnable[0]) nextDly_ff <= avsWriteData[2:0];
                            avsReadData <= {29'h0, nextDly_ff};
                        end
                        `OFS_SEQCTL: begin
                            if (avsWrite && avsByteEnable[0]) seqLen_ff <= avsWriteData[2:0];
                            avsReadData <= {29'h0, seqLen_ff};
                        end
                        `OFS_SEQSTAT: begin
                            avsReadData <= {29'h0, cmdPtr_ff}; // [R20]
                        end
                        `OFS_POLARITY: begin
                            if (avsWrite && avsByteEnable[0]) selPol_ff <= avsWriteData[7:0];
                            avsReadData <= {24'h0, selPol_ff};
                        end
                        default: begin
                            avsReadData <= 32'h00000000;
                        end
                    endcase
                end
            end
        end
    end

    // Master sequencer. Delays count in full serial periods (two half periods).
    always @(posedge clk_sys) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            cmdPtr_ff <= 3'h0;
            rateCnt_ff <= 12'h000;
            halfCnt_ff <= 4'h0;
            edgeCnt_ff <= 5'h00;
            shift_ff <= 16'h0000;
            rxShift_ff <= 16'h0000;
            keepSel_ff <= 1'b0;
            heldSel_ff <= 8'h00;
            busy_ff <= 1'b0;
            sclkOut <= 1'b0;
            sclkOe <= 1'b0;
            mosiOut <= 1'b0;
            selectOut <= 8'h00;
            rxWord <= 16'h0000;
            rxValid <= 1'b0;
        end else begin
            rxValid <= 1'b0;
            sclkOe <= isMaster & isEnabled;
            if (!(isMaster && isEnabled)) begin
                state_ff <= ST_IDLE;
                busy_ff <= 1'b0;
                cmdPtr_ff <= 3'h0;
                sclkOut <= cw0[`CW_CLOCK_POLARITY];
                selectOut <= ~selPol_ff;
            end else begin
                case (state_ff)
                    ST_IDLE: begin
                        sclkOut <= cw[`CW_CLOCK_POLARITY]; // [R15]
                        selectOut <= keepSel_ff ? heldSel_ff : ~selPol_ff; // [R9]
                        if (startPend_ff && !busy_ff) begin
                            busy_ff <= 1'b1;
                            selectOut <= selOf(cw[`CW_SEL_HI:`CW_SEL_LO], selPol_ff,
                                ctrl_ff[`CTL_MULTI], ctrl_ff[`CTL_FOURSEL]); // [R1]
                            shift_ff <= cw[`CW_LSB_FIRST] ? txWord :
                                bitRev(txWord) >> (5'h10 - bitLen); // [R7]
                            // The first shift half period ends the lead, so code k waits 2k+1 here
                            halfCnt_ff <= cw[`CW_LEAD_EN] ? {leadDly_ff, 1'b0} : 4'h0; // [R3] [R22]
                            rateCnt_ff <= 12'h000;
                            edgeCnt_ff <= 5'h00;
                            state_ff <= ST_LEAD;
                        end
                    end
                    ST_LEAD, ST_NEG, ST_NEXT: begin
                        if (rateCnt_ff == halfPeriod - 12'h001) begin
                            rateCnt_ff <= 12'h000;
                            if (halfCnt_ff == 4'h0) begin
                                if (state_ff == ST_LEAD) begin
                                    state_ff <= ST_SHIFT;
                                    if (!cw[`CW_CLOCK_PHASE]) mosiOut <= shift_ff[0]; // [R16]
                                end else if (state_ff == ST_NEG) begin
                                    keepSel_ff <= cw[`CW_KEEP];
                                    heldSel_ff <= selectOut;
                                    if (!cw[`CW_KEEP]) selectOut <= ~selPol_ff; // [R9]
                                    halfCnt_ff <= cw[`CW_NEXT_EN] ? {nextDly_ff, 1'b1} : 4'h1; // [R5]
                                    state_ff <= ST_NEXT;
                                end else begin
                                    halfCnt_ff <= `NEXT_EXTRA_CLKS - 4'h1; // [R5]
                                    state_ff <= ST_EXTRA;
                                end
                            end else begin
                                halfCnt_ff <= halfCnt_ff - 4'h1;
                            end
                        end else begin
                            rateCnt_ff <= rateCnt_ff + 12'h001;
                        end
                    end
                    ST_SHIFT: begin
                        if (rateCnt_ff == halfPeriod - 12'h001) begin
                            rateCnt_ff <= 12'h000;
                            sclkOut <= ~sclkOut;
                            edgeCnt_ff <= edgeCnt_ff + 5'h01;
                            // Odd edges sample when phase is 0, even edges otherwise
                            if (edgeCnt_ff[0] == cw[`CW_CLOCK_PHASE]) begin // [R16]
                                rxShift_ff <= cw[`CW_LSB_FIRST] ?
                                    {misoIn, rxShift_ff[15:1]} : {rxShift_ff[14:0], misoIn};
                            end else begin
                                // Phase 0 already shows bit 0 before the first edge
                                mosiOut <= cw[`CW_CLOCK_PHASE] ? shift_ff[0] : shift_ff[1];
                                shift_ff <= shift_ff >> 1;
                            end
                            if (edgeCnt_ff == {bitLen[3:0], 1'b0} - 5'h01) begin
                                halfCnt_ff <= cw[`CW_NEG_EN] ? {negDly_ff, 1'b1} : 4'h1; // [R4]
                                state_ff <= ST_NEG;
                            end
                        end else begin
                            rateCnt_ff <= rateCnt_ff + 12'h001;
                        end
                    end
                    ST_EXTRA: begin
                        if (halfCnt_ff == 4'h0) begin
                            rxWord <= cw[`CW_LSB_FIRST] ? rxShift_ff >> (5'h10 - bitLen) :
                                rxShift_ff;
                            rxValid <= 1'b1;
                            cmdPtr_ff <= (cmdPtr_ff == seqLen_ff) ? 3'h0 : cmdPtr_ff + 3'h1; // [R23] [R1]
                            busy_ff <= 1'b0;
                            state_ff <= ST_IDLE;
                        end else begin
                            halfCnt_ff <= halfCnt_ff - 4'h1;
                        end
                    end
                    default: begin
                        state_ff <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // MSB-first words are reversed so the shifter always sends bit 0 first
    function [15:0] bitRev;
        input [15:0] w;
        integer k;
        begin
            for (k = 0; k < 16; k = k + 1) begin
                bitRev[k] = w[15-k];
            end
        end
    endfunction

    // Slave receiver: pins pass three flops, an edge counts when the last two differ
    wire slvClk = sclkSync_ff[2] ^ cw0[`CW_CLOCK_POLARITY]; // [R15] [R19]
    wire slvEdge = (sclkSync_ff[1] == sclkSync_ff[2]) ? 1'b0 : 1'b1;
    wire slvSel = selSync_ff[2] == selPol_ff[0];
    wire slvSample = slvEdge && ((sclkSync_ff[1] ^ cw0[`CW_CLOCK_POLARITY]) != cw0[`CW_CLOCK_PHASE]); // [R16]
    always @(posedge clk_sys) begin
        if (rst) begin
            sclkSync_ff <= 3'h0;
            selSync_ff <= 3'h0;
            mosiSync_ff <= 3'h0;
            slvCnt_ff <= 5'h00;
            slvShift_ff <= 16'h0000;
            slvOut_ff <= 16'h0000;
            slaveMisoOut <= 1'b0;
        end else begin
            sclkSync_ff <= {sclkSync_ff[1:0], sclkIn};
            selSync_ff <= {selSync_ff[1:0], selectIn0};
            mosiSync_ff <= {mosiSync_ff[1:0], mosiIn};
            if (isMaster || !isEnabled || !slvSel) begin // [R2]
                slvCnt_ff <= 5'h00;
                slvOut_ff <= cw0[`CW_LSB_FIRST] ? txWord : bitRev(txWord) >> (5'h10 - bitLen0);
                slaveMisoOut <= cw0[`CW_LSB_FIRST] ? txWord[0] :
                    txWord[bitLen0[3:0] - 4'h1]; // [R7]
            end else if (slvSample) begin
                slvShift_ff <= cw0[`CW_LSB_FIRST] ? {mosiSync_ff[2], slvShift_ff[15:1]} :
                    {slvShift_ff[14:0], mosiSync_ff[2]};
                slvOut_ff <= slvOut_ff >> 1;
                slvCnt_ff <= (slvCnt_ff == bitLen0 - 5'h01) ? 5'h00 : slvCnt_ff + 5'h01; // [R8]
            end else if (slvEdge) begin
                slaveMisoOut <= slvOut_ff[0];
            end
        end
    end
endmodule

// [test/spi_cmd_bank_sva.sv]
// Port assertions for the command bank
module spi_cmd_bank_sva (
    // System
    input wire clk_sys,
    input wire rst,
    // Register bus
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsReadData,
    input wire avsWaitRequest,
    // Serial side
    input wire rxValid,
    input wire sclkOut,
    input wire [7:0] selectOut
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    wire req = avsRead || avsWrite;
    chk_bus_answer: assert property (req && avsWaitRequest |=> !avsWaitRequest)
        else $error("request not answered");
    chk_wait_single: assert property (!avsWaitRequest |=> avsWaitRequest)
        else $error("waitrequest low too long");
    chk_wait_idle: assert property (!req |=> avsWaitRequest)
        else $error("waitrequest low without request");
    chk_rdata_hold: assert property ($changed(avsReadData) |-> !avsWaitRequest)
        else $error("read data moved outside an answer");
    chk_rx_pulse: assert property (rxValid |=> !rxValid)
        else $error("receive strobe too long");
    chk_clock_rest: assert property (rxValid |-> $stable(sclkOut) ##1 $stable(sclkOut))
        else $error("serial clock moving at word end");
    chk_select_steady: assert property ($changed(sclkOut) |-> $stable(selectOut))
        else $error("select moved with a clock edge");
    chk_lead_gap: assert property ($changed(selectOut) |-> ##1 $stable(sclkOut))
        else $error("clock edge right after select change");
    cov_read: cover property (avsRead && !avsWaitRequest);
    cov_write: cover property (avsWrite && !avsWaitRequest);
    cov_word: cover property (rxValid);
endmodule

bind spi_command_format_bank spi_cmd_bank_sva i_sva (.clk_sys(clk_sys), .rst(rst),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .rxValid(rxValid), .sclkOut(sclkOut),
    .selectOut(selectOut));

// [test/serial_slave_model.sv]
// Serial slave standing on the far side of the command bank
module serial_slave_model #(
    parameter logic [15:0] RESP = 16'h0000
) (
    // System
    input wire clk_sys,
    input wire clr,
    // Format of the running word
    input wire [15:0] fmt,
    // Serial pins
    input wire sel,
    input wire sclk,
    input wire mosi,
    output logic miso,
    output logic [15:0] got
);
    timeunit 1ns;
    timeprecision 1ps;
    int edgeNo = 0;
    int len;
    int idx;
    logic prevSclk = 0;
    logic junk = 0;
    always @* begin
        len = fmt[11] ? fmt[11:8] + 1 : 8;
        idx = fmt[0] ? (edgeNo - 1) / 2 : edgeNo / 2;
        if (idx < 0) idx = 0;
        if (idx >= len) idx = len - 1;
        // Released line toggles so a stale bit cannot pass for data
        miso = sel ? RESP[fmt[12] ? idx : len - 1 - idx] : junk;
    end
    always @(posedge clk_sys) begin
        prevSclk <= sclk;
        junk <= ~junk;
        if (clr) begin
            edgeNo <= 0;
            got <= 16'h0000;
        end else if (sclk !== prevSclk && (edgeNo > 0 || sclk !== fmt[1])) begin
            edgeNo <= edgeNo + 1;
            if (edgeNo[0] == fmt[0]) got <= {got[14:0], mosi};
        end
    end
endmodule

// [test/tb.sv]
// Self-checking bench for the command bank
`include "spi_cmd_bank_regs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] RESP = 16'hc3a5;
    logic clk_sys = 0;
    logic rst = 1;
    logic [5:0] avsAddress = 6'h00;
    logic avsRead = 0;
    logic avsWrite = 0;
    logic [31:0] avsWriteData = 32'h0;
    logic [3:0] avsByteEnable = 4'hf;
    logic [15:0] txWord = 16'h0;
    logic [15:0] fmt = 16'h0;
    logic clr = 1;
    logic [7:0] pol = 8'h5a;
    logic [31:0] ctl = 32'h3;
    logic [31:0] q;
    logic [15:0] w;
    logic [15:0] seqW [3] = '{16'h07a0, 16'h0f21, 16'h0851};
    wire [31:0] avsReadData;
    wire [15:0] rxWord, got;
    wire [7:0] selectOut;
    wire avsWaitRequest, rxValid, sclkOut, sclkOe, mosiOut, slaveMisoOut, misoIn;
    wire selAct = |(selectOut ~^ pol);
    int br = 1;
    int numErrors = 0;
    int totalChecks = 0;
    int cyc = 0;
    int tSel, tFirst, tLast, tNeg, tRx, edges;
    logic [7:0] selSeen;
    logic prevSel = 0;
    logic prevSclk = 0;
    bit prevKeep = 0;
    spi_command_format_bank i_dut (.clk_sys(clk_sys), .rst(rst), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
        .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .txWord(txWord), .rxWord(rxWord),
        .rxValid(rxValid), .sclkOut(sclkOut), .sclkOe(sclkOe), .sclkIn(1'b0),
        .mosiOut(mosiOut), .misoIn(misoIn), .slaveMisoOut(slaveMisoOut),
        .mosiIn(1'b0), .selectOut(selectOut), .selectIn0(1'b1));
    serial_slave_model #(.RESP(RESP)) i_slave (.clk_sys(clk_sys), .clr(clr), .fmt(fmt),
        .sel(selAct), .sclk(sclkOut), .mosi(mosiOut), .miso(misoIn), .got(got));
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        prevSel <= selAct;
        prevSclk <= sclkOut;
        if (clr) begin
            edges <= 0;
            selSeen <= 8'h00;
        end else begin
            if (selAct && !prevSel) tSel <= cyc;
            if (!selAct && prevSel) tNeg <= cyc;
            // A shift of idle level between words is not a clock edge
            if (sclkOut !== prevSclk && (edges > 0 || sclkOut !== fmt[1])) begin
                if (edges == 0) tFirst <= cyc;
                tLast <= cyc;
                edges <= edges + 1;
            end
            if (rxValid) tRx <= cyc;
            selSeen <= selSeen | (selectOut ~^ pol);
        end
        if (cyc == 60000) begin
            numErrors++;
            finalReport();
        end
    end
    task automatic finalReport();
        $display("checks %0d mismatches %0d", totalChecks, numErrors);
        if (numErrors == 0 && totalChecks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            numErrors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input bit wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avsAddress <= a;
        avsWriteData <= d;
        avsRead <= !wr;
        avsWrite <= wr;
        do @(posedge clk_sys); while (avsWaitRequest !== 1'b0 && n++ < 100);
        if (n > 100) numErrors++;
        q = avsReadData;
        avsRead <= 0;
        avsWrite <= 0;
        @(posedge clk_sys);
    endtask
    task automatic rdchk(input string nm, input logic [5:0] a, input logic [31:0] exp);
        bus(0, a, 32'h0);
        check(nm, q, exp);
    endtask
    task automatic run(input logic [15:0] cw, input logic [15:0] tx, input bit selExp);
        int len, half, n;
        logic [31:0] m, e;
        len = cw[11] ? cw[11:8] + 1 : 8;
        half = (br + 1) << cw[3:2];
        m = (32'h1 << len) - 1;
        e = 0;
        n = 0;
        for (int i = 0; i < len; i++) e[cw[12] ? len - 1 - i : i] = tx[i];
        fmt <= cw;
        txWord <= tx;
        clr <= 1;
        @(posedge clk_sys);
        clr <= 0;
        bus(1, `OFS_CTRL, ctl | 32'h8);
        while (rxValid !== 1'b1 && n++ < 3000) @(posedge clk_sys);
        if (n > 3000) numErrors++;
        @(posedge clk_sys);
        check("clock enable", sclkOe, 1);
        check("edges", edges, 2 * len);
        check("span", tLast - tFirst, (2 * len - 1) * half);
        check("idle clock", sclkOut, cw[1]);
        check("keep", selAct, cw[7] & selExp);
        check("select", selSeen, selExp ? 8'h1 << cw[6:4] : 8'h0);
        if (selExp) begin
            check("tx", got & m, e);
            check("rx", rxWord & m, RESP & m);
            if (!prevKeep) check("lead", tFirst - tSel, (cw[15] ? 4 : 1) * 2 * half);
            if (!cw[7]) check("negate", tNeg - tLast, (cw[14] ? 3 : 1) * 2 * half);
            if (!cw[7]) check("next", tRx - tNeg, (cw[13] ? 2 : 1) * 2 * half + 2);
        end
        prevKeep = cw[7] & selExp;
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 0;
        @(posedge clk_sys);
        for (int i = 0; i < 8; i++) rdchk("reset word", `OFS_CMD_BASE + 4 * i, `CW_RESET);
        rdchk("pointer", `OFS_SEQSTAT, 0);
        bus(1, `OFS_SEQSTAT, 32'h3);
        rdchk("pointer", `OFS_SEQSTAT, 0);
        $display("test reset done");
        bus(1, `OFS_BITRATE, br);
        bus(1, `OFS_POLARITY, pol);
        for (int c = 0; c < 16; c++) begin
            w = {3'b000, c[2], c[3:0], 1'b0, c[2:0], c[3:0]};
            bus(1, `OFS_CMD_BASE, w);
            rdchk("word", `OFS_CMD_BASE, w);
            run(w, 16'h5a3c ^ c[15:0], 1);
        end
        $display("test formats done");
        bus(1, `OFS_LEADDLY, 32'h3);
        bus(1, `OFS_NEGDLY, 32'h2);
        bus(1, `OFS_NEXTDLY, 32'h1);
        bus(1, `OFS_CMD_BASE, 32'he030);
        run(16'he030, 16'h00c6, 1);
        $display("test delays done");
        for (int i = 0; i < 3; i++) bus(1, `OFS_CMD_BASE + 4 * i, seqW[i]);
        bus(1, `OFS_SEQCTL, 32'h2);
        for (int i = 0; i < 6; i++) begin
            run(seqW[i % 3], 16'hb1e7, 1);
            rdchk("pointer", `OFS_SEQSTAT, (i + 1) % 3);
        end
        $display("test sequence done");
        bus(1, `OFS_SEQCTL, 32'h0);
        ctl = 32'h7;
        bus(1, `OFS_CMD_BASE, 32'h0700);
        run(16'h0700, 16'h0011, 0);
        ctl = 32'h13;
        bus(1, `OFS_CMD_BASE, 32'h0750);
        run(16'h0750, 16'h0022, 0);
        $display("test negated selects done");
        finalReport();
    end
endmodule
